// >>> hdl/gpio18_cfg.svh
// constants of the 18-line parallel i/o block: offsets, layouts, resets
// Function
// - pin level register returns sensed pin levels
// - open-drain set/clear ones change line drive mode
// - open-drain state reads one per open-drain line
// - clock-on bit0 enables, clock-off bit0 disables
// - clock state bit0 shows block clock enabled
// - control bit0 resets all but clock state
// - any pin edge while the block clock is on sets its sticky event flag, unless a soft reset falls in that cycle
// - event flag read returns then clears ones
// - event flags zero after any reset
// - per-line mask bit, mask state reads back
// - masked lines never raise the block interrupt
// - mask set/clear ones change mask bits
// - interrupt high while flag and mask both set
// - bits 18 to 31 ignored, read zero
`ifndef GPIO18_CFG_SVH
`define GPIO18_CFG_SVH

// number of parallel i/o lines
`define LINE_W 18

// register byte addresses; decode looks at address bits 7:2 only
`define OFF_OUT_EN_SET 32'hFFFD_8010
`define OFF_OUT_EN_CLR 32'hFFFD_8014
`define OFF_OUT_EN_STATE 32'hFFFD_8018
`define OFF_OUT_DATA_SET 32'hFFFD_8030
`define OFF_OUT_DATA_CLR 32'hFFFD_8034
`define OFF_OUT_DATA_STATE 32'hFFFD_8038
`define OFF_PIN_LEVEL_STATUS 32'hFFFD_8030
`define OFF_OPEN_DRAIN_SET 32'hFFFD_8040
`define OFF_OPEN_DRAIN_CLEAR 32'hFFFD_8044
`define OFF_OPEN_DRAIN_STATE 32'hFFFD_8048
`define OFF_BLOCK_CLOCK_ON 32'hFFFD_8050
`define OFF_BLOCK_CLOCK_OFF 32'hFFFD_8054
`define OFF_BLOCK_CLOCK_STATE 32'hFFFD_8058
`define OFF_CONTROL_STROBE 32'hFFFD_8060
`define OFF_EDGE_EVENT_FLAGS 32'hFFFD_8070
`define OFF_IRQ_MASK_SET 32'hFFFD_8074
`define OFF_IRQ_MASK_CLEAR 32'hFFFD_8078
`define OFF_IRQ_MASK_STATE 32'h0000_007C

// field positions
`define CLK_BIT 0
`define SOFT_RESET_BIT 0

// reset values
`define RST_LINES 18'h0_0000
`define RST_CLK_ON 1'b0

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> hdl/gpio18_pkg.sv
// types shared by the parallel i/o block files
package gpio18_pkg;
`include "gpio18_cfg.svh"

   // one bit per line
   typedef logic [`LINE_W-1:0] line_t;

   // register write handed from the bus slave to the register file
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } wr_req_t;

   // register read answer handed back to the bus slave
   typedef struct packed {
      logic [31:0] data;
      logic err;
   } rd_ans_t;
endpackage

// >>> hdl/gpio18_axil_slave.sv
// axi4-lite slave front end: turns bus traffic into register strobes
`timescale 1ns/1ps
module gpio18_axil_slave
   import gpio18_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr,
   output wr_req_t wr_req,
   input wire logic wr_err,
   output logic rd,
   output logic [31:0] rd_addr,
   input wire rd_ans_t rd_ans
);
   logic aw_full_q; // write address held
   logic w_full_q; // write data held
   logic [31:0] aw_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   logic aw_take;
   logic w_take;

   assign aw_take = awvalid & awready;
   assign w_take = wvalid & wready;
   // write fires once both halves are held and the last answer is gone
   assign wr = aw_full_q & w_full_q & ~bvalid;
   assign wr_req = '{addr: aw_q, data: wd_q, strb: ws_q};
   // read is taken in the handshake cycle so flags clear exactly once
   assign rd = arvalid & arready;
   assign rd_addr = araddr;

   // address and data channels latch independently, in either order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         aw_q <= 32'h0000_0000;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
      end else begin
         aw_full_q <= (aw_full_q & ~wr) | aw_take;
         w_full_q <= (w_full_q & ~wr) | w_take;
         awready <= ~((aw_full_q & ~wr) | aw_take);
         wready <= ~((w_full_q & ~wr) | w_take);
         if (aw_take) begin
            aw_q <= awaddr;
         end
         if (w_take) begin
            wd_q <= wdata;
            ws_q <= wstrb;
         end
      end
   end

   // write response, one outstanding
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (wr) begin
         bvalid <= 1'b1;
         bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // read data registered one cycle after the address is taken
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
      end else if (rd) begin
         rvalid <= 1'b1;
         arready <= 1'b0;
         rdata <= rd_ans.data;
         rresp <= rd_ans.err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (rvalid & rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule

// >>> hdl/gpio18_pin_sync.sv
// per-line pin synchroniser and edge detector
`timescale 1ns/1ps
module gpio18_pin_sync
   import gpio18_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire line_t pins,
   output line_t level,
   output line_t edge_seen
);
   genvar i;
   generate
      for (i = 0; i < `LINE_W; i++) begin : g_line
         logic s1_q; // first stage, read only by s2_q
         logic s2_q; // settled level
         logic s3_q; // level one cycle older
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
            end else begin
               s1_q <= pins[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         assign level[i] = s2_q;
         // either direction of change counts
         assign edge_seen[i] = s2_q ^ s3_q;
      end
   endgenerate
endmodule

// >>> hdl/gpio18_top.sv
// 18-line parallel i/o block with axi4-lite register access
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gpio18_top
   import gpio18_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire line_t PIN_IN,
   output line_t PIN_OUT,
   output line_t PIN_OE,
   output logic IRQ
);
   // bus side strobes
   logic wr; // one-cycle register write
   wr_req_t wr_req; // address, data and lanes of that write
   logic wr_err; // write to no writable register
   logic rd; // one-cycle register read
   logic [31:0] rd_addr; // address of that read
   rd_ans_t rd_ans; // data and error for that read

   // pin side
   line_t level; // synchronised pin levels
   line_t edge_seen; // change seen this cycle

   // register state
   line_t out_en_q; // line drives its pin
   line_t out_data_q; // level driven on the pin
   line_t od_q; // line is open drain
   line_t mask_q; // interrupt enabled per line
   line_t flags_q; // sticky edge events
   logic clk_on_q; // block clock enabled
   line_t pin_out_q; // registered pin value
   line_t pin_oe_q; // registered pin enable
   logic irq_q; // registered interrupt

   // write decode
   logic [31:0] wmask; // byte lanes widened to bits
   line_t wl; // written line bits, lanes applied
   logic srst; // soft reset strobe
   logic w_oe_set;
   logic w_oe_clr;
   logic w_od_set;
   logic w_od_clr;
   logic w_os_set;
   logic w_os_clr;
   logic w_clk_on;
   logic w_clk_off;
   logic w_mk_set;
   logic w_mk_clr;
   logic w_ctl;

   // read decode
   logic rd_flags; // this read returns the event flags
   line_t evt; // edges counted while the clock is on
   line_t clr; // flags cleared by the read

   gpio18_axil_slave u_bus (
      .clk(SYS_CLK),
      .rst_n(ARST_N),
      .awaddr(S_AXI_AWADDR),
      .awvalid(S_AXI_AWVALID),
      .awready(S_AXI_AWREADY),
      .wdata(S_AXI_WDATA),
      .wstrb(S_AXI_WSTRB),
      .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY),
      .bresp(S_AXI_BRESP),
      .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY),
      .araddr(S_AXI_ARADDR),
      .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY),
      .rdata(S_AXI_RDATA),
      .rresp(S_AXI_RRESP),
      .rvalid(S_AXI_RVALID),
      .rready(S_AXI_RREADY),
      .wr(wr),
      .wr_req(wr_req),
      .wr_err(wr_err),
      .rd(rd),
      .rd_addr(rd_addr),
      .rd_ans(rd_ans)
   );

   gpio18_pin_sync u_sync (
      .clk(SYS_CLK),
      .rst_n(ARST_N),
      .pins(PIN_IN),
      .level(level),
      .edge_seen(edge_seen)
   );

   // only address bits 7:2 are compared; the block aliases every 256 bytes
   function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction

   assign wmask = {{8{wr_req.strb[3]}}, {8{wr_req.strb[2]}},
                   {8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}};
   // bits above the last line are simply dropped
   assign wl = line_t'(wr_req.data & wmask);

   // write strobes per register
   assign w_oe_set = wr & hit(wr_req.addr, `OFF_OUT_EN_SET);
   assign w_oe_clr = wr & hit(wr_req.addr, `OFF_OUT_EN_CLR);
   assign w_os_set = wr & hit(wr_req.addr, `OFF_OUT_DATA_SET);
   assign w_os_clr = wr & hit(wr_req.addr, `OFF_OUT_DATA_CLR);
   assign w_od_set = wr & hit(wr_req.addr, `OFF_OPEN_DRAIN_SET);
   assign w_od_clr = wr & hit(wr_req.addr, `OFF_OPEN_DRAIN_CLEAR);
   assign w_clk_on = wr & hit(wr_req.addr, `OFF_BLOCK_CLOCK_ON);
   assign w_clk_off = wr & hit(wr_req.addr, `OFF_BLOCK_CLOCK_OFF);
   assign w_mk_set = wr & hit(wr_req.addr, `OFF_IRQ_MASK_SET);
   assign w_mk_clr = wr & hit(wr_req.addr, `OFF_IRQ_MASK_CLEAR);
   assign w_ctl = wr & hit(wr_req.addr, `OFF_CONTROL_STROBE);
   // a zero in the reset bit does nothing
   assign srst = w_ctl & wmask[`SOFT_RESET_BIT] & wr_req.data[`SOFT_RESET_BIT];
   // writes that hit no writable register answer slverr
   assign wr_err = ~(w_oe_set | w_oe_clr | w_os_set | w_os_clr | w_od_set | w_od_clr
                     | w_clk_on | w_clk_off | w_mk_set | w_mk_clr | w_ctl);

   // output enable set/clear pair
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         out_en_q <= `RST_LINES;
      end else if (srst) begin
         out_en_q <= `RST_LINES;
      end else begin
         out_en_q <= (out_en_q | (w_oe_set ? wl : '0)) & ~(w_oe_clr ? wl : '0);
      end
   end

   // output data set/clear pair
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         out_data_q <= `RST_LINES;
      end else if (srst) begin
         out_data_q <= `RST_LINES;
      end else begin
         out_data_q <= (out_data_q | (w_os_set ? wl : '0)) & ~(w_os_clr ? wl : '0);
      end
   end

   // open-drain mode per line; zeros leave lines alone
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         od_q <= `RST_LINES;
      end else if (srst) begin
         od_q <= `RST_LINES;
      end else begin
         od_q <= (od_q | (w_od_set ? wl : '0)) & ~(w_od_clr ? wl : '0);
      end
   end

   // block clock enable; soft reset leaves it alone on purpose
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         clk_on_q <= `RST_CLK_ON;
      end else if (w_clk_on & wmask[`CLK_BIT] & wr_req.data[`CLK_BIT]) begin
         clk_on_q <= 1'b1;
      end else if (w_clk_off & wmask[`CLK_BIT] & wr_req.data[`CLK_BIT]) begin
         clk_on_q <= 1'b0;
      end
   end

   // interrupt mask set/clear pair
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mask_q <= `RST_LINES;
      end else if (srst) begin
         mask_q <= `RST_LINES;
      end else begin
         mask_q <= (mask_q | (w_mk_set ? wl : '0)) & ~(w_mk_clr ? wl : '0);
      end
   end

   // edges only count while the block clock is on, like a gated clock would
   assign evt = edge_seen & {`LINE_W{clk_on_q}};
   assign rd_flags = rd & hit(rd_addr, `OFF_EDGE_EVENT_FLAGS);
   // clear exactly what the read returned
   assign clr = rd_flags ? flags_q : '0;

   // sticky edge flags; a new edge beats the read clear
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         flags_q <= `RST_LINES;
      end else if (srst) begin
         flags_q <= `RST_LINES;
      end else begin
         flags_q <= (flags_q & ~clr) | evt;
      end
   end

   // pin drivers: open drain never drives a high
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pin_out_q <= `RST_LINES;
         pin_oe_q <= `RST_LINES;
      end else begin
         pin_out_q <= out_data_q & ~od_q;
         pin_oe_q <= out_en_q & ~(od_q & out_data_q);
      end
   end

   // block interrupt from flagged and unmasked lines only
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags_q & mask_q);
      end
   end

   assign PIN_OUT = pin_out_q;
   assign PIN_OE = pin_oe_q;
   assign IRQ = irq_q;

   // read mux; unused upper bits stay zero
   always_comb begin
      rd_ans = '{data: 32'h0000_0000, err: 1'b0};
      if (hit(rd_addr, `OFF_PIN_LEVEL_STATUS)) begin
         rd_ans.data = {14'h0000, level};
      end else if (hit(rd_addr, `OFF_OUT_EN_STATE)) begin
         rd_ans.data = {14'h0000, out_en_q};
      end else if (hit(rd_addr, `OFF_OUT_DATA_STATE)) begin
         rd_ans.data = {14'h0000, out_data_q};
      end else if (hit(rd_addr, `OFF_OPEN_DRAIN_STATE)) begin
         rd_ans.data = {14'h0000, od_q};
      end else if (hit(rd_addr, `OFF_BLOCK_CLOCK_STATE)) begin
         rd_ans.data = {31'h0000_0000, clk_on_q};
      end else if (hit(rd_addr, `OFF_EDGE_EVENT_FLAGS)) begin
         rd_ans.data = {14'h0000, flags_q};
      end else if (hit(rd_addr, `OFF_IRQ_MASK_STATE)) begin
         rd_ans.data = {14'h0000, mask_q};
      end else begin
         // write-only or unmapped address
         rd_ans.err = 1'b1;
      end
   end

   // checks on the block's own behaviour
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);

   // pin level reaches the read data two edges after the pin
   AST_PIN_LEVEL: assert property (
      rd & hit(rd_addr, `OFF_PIN_LEVEL_STATUS) |-> rd_ans.data[`LINE_W-1:0] == $past(PIN_IN, 2))
      else $error("pin level read differs from pin");

   AST_OD_SET: assert property (
      w_od_set & ~w_od_clr & ~srst |=> (od_q & $past(wl)) == $past(wl))
      else $error("open-drain set write lost");

   AST_OD_CLR: assert property (
      w_od_clr & ~srst |=> (od_q & $past(wl)) == '0)
      else $error("open-drain clear write lost");

   AST_OD_STATE: assert property (
      rd & hit(rd_addr, `OFF_OPEN_DRAIN_STATE) |=> S_AXI_RDATA == {14'h0000, $past(od_q)})
      else $error("open-drain state read wrong");

   AST_CLK_ON: assert property (
      w_clk_on & wr_req.data[0] & wr_req.strb[0] |=> clk_on_q)
      else $error("clock on write ignored");

   AST_CLK_STATE: assert property (
      rd & hit(rd_addr, `OFF_BLOCK_CLOCK_STATE) |=> S_AXI_RDATA == {31'h0, $past(clk_on_q)})
      else $error("clock state read wrong");

   AST_SOFT_RESET: assert property (
      srst |=> mask_q == '0 && od_q == '0 && out_en_q == '0 && clk_on_q == $past(clk_on_q))
      else $error("soft reset result wrong");

   AST_SRST_FLAGS: assert property (
      srst |=> flags_q == '0)
      else $error("flags survive soft reset");

   AST_EDGE_FLAG: assert property (
      clk_on_q && edge_seen != '0 && !srst |=> (flags_q & $past(edge_seen)) == $past(edge_seen))
      else $error("edge not recorded");

   AST_CLOCK_OFF: assert property (
      !clk_on_q && !rd_flags && !srst |=> flags_q == $past(flags_q))
      else $error("flags moved with block clock off");

   AST_READ_CLEAR: assert property (
      rd_flags && !srst |=> flags_q == $past(evt))
      else $error("read did not clear flags");

   AST_MASK_SET: assert property (
      w_mk_set & ~w_mk_clr & ~srst |=> (mask_q & $past(wl)) == $past(wl))
      else $error("mask set write lost");

   AST_MASK_READ: assert property (
      rd & hit(rd_addr, `OFF_IRQ_MASK_STATE) |=> S_AXI_RDATA == {14'h0000, $past(mask_q)})
      else $error("mask state read wrong");

   AST_IRQ: assert property (
      ##1 IRQ == |($past(flags_q) & $past(mask_q)))
      else $error("interrupt does not follow flags and mask");

   AST_MASKED_QUIET: assert property (
      mask_q == '0 ##1 mask_q == '0 |=> !IRQ)
      else $error("masked lines raised interrupt");

   AST_UPPER_ZERO: assert property (
      S_AXI_RVALID |-> S_AXI_RDATA[31:`LINE_W] == '0)
      else $error("undefined bits read nonzero");

   AST_EDGE_WINS: assert property (
      rd_flags && evt != '0 && !srst |=> (flags_q & $past(evt)) == $past(evt))
      else $error("edge lost during clearing read");

   // main scenarios
   COV_EDGE_IRQ: cover property (evt != '0 ##[1:3] IRQ);
   COV_READ_RACE: cover property (rd_flags && evt != '0);
   COV_SOFT_RESET: cover property (srst && clk_on_q);
   COV_OD_LOW: cover property (w_od_set ##1 od_q != '0);
endmodule

// >>> sim/gpio18_pin_partner.sv
// external circuit model on the 18 parallel i/o pins
`timescale 1ns/1ps
module gpio18_pin_partner
   import gpio18_pkg::*;
(
   input wire line_t pin_out, // value the block drives
   input wire line_t pin_oe, // high where the block drives the pin
   input wire line_t ext_lvl, // level the outside circuit (or pull-up) gives
   output line_t pin_in // resolved wire level fed back to the block
);
   // a driven pin follows the block, otherwise the outside circuit wins;
   // open-drain lines not driving low float to ext_lvl, which the bench sets to all ones for the drive test, as a pull-up would
   always_comb begin
      for (int i = 0; i < `LINE_W; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
      end
   end
endmodule

// >>> sim/gpio18_top_tb.sv
// self-checking bench for the 18-line parallel i/o block
`timescale 1ns/1ps
`include "gpio18_cfg.svh"
module gpio18_top_tb
   import gpio18_pkg::*;
;
   logic clk = 1'b0; // 200 mhz system clock
   logic arst_n = 1'b0; // held low for three edges
   logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   line_t ext_lvl = 18'h0_0000; // outside circuit level
   line_t pin_in, pin_out, pin_oe;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0; // cycle counter for the hang guard

   always #2.5 clk = ~clk;

   gpio18_top dut (.SYS_CLK(clk), .ARST_N(arst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .IRQ(irq));

   gpio18_pin_partner pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

   // compare one value and count it
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // axi write: address and data offered together, each dropped once taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(aw_done && w_done));
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask

   // axi read with expected data and response
   task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
      chk({what, " resp"}, {30'h0, rresp}, {30'h0, er});
      chk(what, d, exp);
   endtask

   // change outside pin levels off the edge and let the sync and edge logic settle
   task automatic drive_pins(input line_t v);
      @(posedge clk);
      ext_lvl <= v;
      repeat (6) @(posedge clk);
   endtask

   // hang guard: far above what the sequence needs
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         results();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      // reset values
      rchk("od state", `OFF_OPEN_DRAIN_STATE, 32'h0000_0000, `RESP_OKAY);
      rchk("mask state", `OFF_IRQ_MASK_STATE, 32'h0000_0000, `RESP_OKAY);
      rchk("clk state", `OFF_BLOCK_CLOCK_STATE, 32'h0000_0000, `RESP_OKAY);
      rchk("flags", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0000, `RESP_OKAY);
      $display("test reset done");
      // open drain set and clear, undefined bits ignored
      wr(`OFF_OPEN_DRAIN_SET, 32'hFFFF_FFFF, `RESP_OKAY);
      rchk("od all", `OFF_OPEN_DRAIN_STATE, 32'h0003_FFFF, `RESP_OKAY);
      wr(`OFF_OPEN_DRAIN_CLEAR, 32'hFFFC_0005, `RESP_OKAY);
      rchk("od clr", `OFF_OPEN_DRAIN_STATE, 32'h0003_FFFA, `RESP_OKAY);
      wr(`OFF_OPEN_DRAIN_SET, 32'h0000_0000, `RESP_OKAY);
      rchk("od zero", `OFF_OPEN_DRAIN_STATE, 32'h0003_FFFA, `RESP_OKAY);
      $display("test open drain done");
      // pin levels, clock still off so no flags
      drive_pins(18'h2_A5A5);
      rchk("pins", `OFF_PIN_LEVEL_STATUS, 32'h0002_A5A5, `RESP_OKAY);
      rchk("flags off", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0000, `RESP_OKAY);
      drive_pins(18'h1_5A5A);
      rchk("pins inv", `OFF_PIN_LEVEL_STATUS, 32'h0001_5A5A, `RESP_OKAY);
      $display("test pin level done");
      // clock on, then edges set flags and a read clears them
      wr(`OFF_BLOCK_CLOCK_ON, 32'h0000_0001, `RESP_OKAY);
      rchk("clk on", `OFF_BLOCK_CLOCK_STATE, 32'h0000_0001, `RESP_OKAY);
      drive_pins(18'h1_5A4B);
      rchk("flags", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0011, `RESP_OKAY);
      rchk("flags clr", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0000, `RESP_OKAY);
      $display("test edge flags done");
      // mask and interrupt
      wr(`OFF_IRQ_MASK_SET, 32'hFFFC_0005, `RESP_OKAY);
      wr(`OFF_IRQ_MASK_CLEAR, 32'h0000_0004, `RESP_OKAY);
      rchk("mask", `OFF_IRQ_MASK_STATE, 32'h0000_0001, `RESP_OKAY);
      drive_pins(18'h1_5A49);
      chk("irq masked", {31'h0, irq}, 32'h0000_0000);
      rchk("flag1", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0002, `RESP_OKAY);
      drive_pins(18'h1_5A48);
      chk("irq on", {31'h0, irq}, 32'h0000_0001);
      rchk("flag0", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0001, `RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("irq off", {31'h0, irq}, 32'h0000_0000);
      // line 2 changes so that its edge meets the clearing read in one cycle
      @(posedge clk);
      ext_lvl <= 18'h1_5A4C;
      @(posedge clk);
      rchk("race", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0000, `RESP_OKAY);
      rchk("race kept", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0004, `RESP_OKAY);
      $display("test interrupt done");
      // bad accesses
      rchk("unmapped", 32'hFFFD_8004, 32'h0000_0000, `RESP_SLVERR);
      rchk("wo read", `OFF_IRQ_MASK_SET, 32'h0000_0000, `RESP_SLVERR);
      wr(`OFF_IRQ_MASK_STATE, 32'hFFFF_FFFF, `RESP_SLVERR);
      rchk("ro write", `OFF_IRQ_MASK_STATE, 32'h0000_0001, `RESP_OKAY);
      $display("test bad access done");
      // soft reset clears all but clock state
      drive_pins(18'h1_5A49);
      wr(`OFF_CONTROL_STROBE, 32'h0000_0000, `RESP_OKAY);
      rchk("no sr", `OFF_IRQ_MASK_STATE, 32'h0000_0001, `RESP_OKAY);
      wr(`OFF_CONTROL_STROBE, 32'h0000_0001, `RESP_OKAY);
      rchk("sr od", `OFF_OPEN_DRAIN_STATE, 32'h0000_0000, `RESP_OKAY);
      rchk("sr mask", `OFF_IRQ_MASK_STATE, 32'h0000_0000, `RESP_OKAY);
      rchk("sr flags", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0000, `RESP_OKAY);
      rchk("sr clk", `OFF_BLOCK_CLOCK_STATE, 32'h0000_0001, `RESP_OKAY);
      $display("test soft reset done");
      // clock off stops flag capture
      wr(`OFF_BLOCK_CLOCK_OFF, 32'h0000_0001, `RESP_OKAY);
      rchk("clk off", `OFF_BLOCK_CLOCK_STATE, 32'h0000_0000, `RESP_OKAY);
      drive_pins(18'h3_FFFF);
      rchk("flags off2", `OFF_EDGE_EVENT_FLAGS, 32'h0000_0000, `RESP_OKAY);
      $display("test clock off done");
      // lines 0 and 1 driven push-pull, then open drain; outside level is all ones
      wr(`OFF_OUT_EN_SET, 32'h0000_0003, `RESP_OKAY);
      wr(`OFF_OUT_DATA_SET, 32'h0000_0001, `RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("oe", {14'h0, pin_oe}, 32'h0000_0003);
      chk("out", {14'h0, pin_out}, 32'h0000_0001);
      rchk("pins drv", `OFF_PIN_LEVEL_STATUS, 32'h0003_FFFD, `RESP_OKAY);
      wr(`OFF_OPEN_DRAIN_SET, 32'h0000_0003, `RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("od oe", {14'h0, pin_oe}, 32'h0000_0002);
      chk("od out", {14'h0, pin_out}, 32'h0000_0000);
      rchk("pins od", `OFF_PIN_LEVEL_STATUS, 32'h0003_FFFD, `RESP_OKAY);
      $display("test pin drive done");
      results();
   end
endmodule
